/* design/vc0_res_pkg.sv */
package vc0_res_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [11:0] CAP_OFS = 12'h150;
    localparam logic [11:0] CTRL_OFS = 12'h154;
    localparam logic [11:0] STAT_OFS = 12'h158;

    // ************************************************************
    // Capability word fields
    // ************************************************************
    localparam int CAP_ARB_LSB = 0;
    localparam int CAP_AS_BIT = 14;
    localparam int CAP_SNOOP_BIT = 15;
    localparam int CAP_SLOTS_LSB = 16;
    localparam int CAP_TBL_LSB = 24;
    localparam logic [7:0] CAP_ARB_RST = 8'h09;
    localparam logic [6:0] SLOTS_RST = 7'h7F;
    localparam logic [7:0] TBL_OFS_RST = 8'h04;

    // ************************************************************
    // Control word fields
    // ************************************************************
    localparam int CTRL_MAP_LSB = 0;
    localparam int CTRL_LOAD_BIT = 16;
    localparam int CTRL_SEL_LSB = 17;
    localparam int CTRL_VCID_LSB = 24;
    localparam int CTRL_EN_BIT = 31;
    localparam logic [7:0] TC_MAP_RST = 8'hFF;
    localparam logic [2:0] VC_ID_RST = 3'h0;
    localparam logic VC_EN_RST = 1'b1;

    // ************************************************************
    // Status word fields
    // ************************************************************
    localparam int STAT_TBL_BIT = 16;
    localparam int STAT_NEG_BIT = 17;

    // Port arbitration scheme codes accepted on this channel
    typedef enum logic [2:0] {
        SCHEME_DEFAULT = 3'h0,
        SCHEME_WRR = 3'h3
    } scheme_t;

    // Table load sequencer
    typedef enum logic {
        LOAD_IDLE,
        LOAD_BUSY
    } load_state_t;

endpackage

/* design/table_dirty_flag.sv */
`timescale 1ns/1ns
module table_dirty_flag (
    input wire logic clk,
    input wire logic rst,
    input wire logic set_evt,
    input wire logic clr_evt,
    output logic flag
);

    // ************************************************************
    // Sticky flag
    // ************************************************************
    // Set wins so a table write landing with the load finish is kept
    always_ff @(posedge clk) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (set_evt) begin
            flag <= 1'b1;
        end else if (clr_evt) begin
            flag <= 1'b0;
        end
    end

endmodule

/* design/default_hold.sv */
`timescale 1ns/1ns
module default_hold #(
    parameter int W = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ee_we,
    input wire logic [W-1:0] ee_val,
    input wire logic sw_we,
    input wire logic [W-1:0] sw_val,
    output logic [W-1:0] val
);

    // ************************************************************
    // Field with reset default and EEPROM override
    // ************************************************************
    // EEPROM load outranks a software write in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            val <= RST_VAL;
        end else if (ee_we) begin
            val <= ee_val;
        end else if (sw_we) begin
            val <= sw_val;
        end
    end

endmodule

/* design/vc0_resource_registers.sv */
`timescale 1ns/1ns
// What this block does
// - The arbitration capability byte is read-only and reads 09h, round robin and WRR 128 phases.
// - Time-based WRR belongs only to channel 1, so channel 0 neither advertises nor selects it.
// - Capability bit 14, the advanced_switching_only mark, is read-only zero.
// - Capability bit 15, reject snoop, is read-only zero.
// - Capability bits 22:16 report time slots minus one and reset to 7Fh.
// - Capability bits 31:24 give the table location in sixteen_byte_unit steps, reset 04h.
// - Control bits 7:0 are a writable traffic-class map that resets to FFh.
// - Writing one to control bit 16 applies the table to the arbiter and the bit reads zero.
// - Control bits 19:17 keep only codes 000b and 011b, any other code becomes 000b.
// - Control bits 26:24, the VC ID, are read-only zero.
// - Control bit 31 enables the channel when set, disables it when clear, and resets set.
// - Status bit 16 sets whenever software writes any arbitration table entry.
// - Status bit 16 clears when the hardware finishes a requested table load with no table write in that cycle.
// - Status bit 17 follows VC negotiation in progress and resets to zero.
// - The time slot field and traffic-class map defaults can be replaced by EEPROM values.
module vc0_resource_registers (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic [11:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    input wire logic ARB_TABLE_WR,
    input wire logic ARB_LOAD_DONE,
    input wire logic NEG_PENDING,
    input wire logic EE_LOAD,
    input wire logic [6:0] EE_TIME_SLOTS,
    input wire logic [7:0] EE_TC_MAP,
    output logic [7:0] TC_MAP,
    output logic [6:0] TIME_SLOTS,
    output logic ARB_LOAD,
    output logic [vc0_res_pkg::CTRL_SEL_LSB-15:0] ARB_SELECT,
    output logic VC_ENABLE,
    output logic TABLE_DIRTY
);
    import vc0_res_pkg::*;

    // ************************************************************
    // Decode helpers
    // ************************************************************
    // Full byte address compare, so misaligned accesses are unmapped
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    // Only the two channel 0 schemes survive, time-based WRR folds to the default
    function automatic logic [2:0] legal_scheme(input logic [2:0] code);
        legal_scheme = (code == SCHEME_WRR) ? SCHEME_WRR : SCHEME_DEFAULT;
    endfunction

    logic wr_ctrl;
    logic rd_cap;
    logic rd_ctrl;
    logic rd_stat;
    logic [31:0] cap_word;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;
    logic [31:0] rd_nxt;
    logic [2:0] sel_r;
    logic en_r;
    logic load_r;
    logic neg_r;
    logic dirty;
    logic [7:0] tc_map;
    logic [6:0] slots;
    load_state_t load_state_r;
    load_state_t load_state_nxt;

    // Strobe qualification
    assign wr_ctrl = REG_WR && hit(REG_ADDR, CTRL_OFS);
    assign rd_cap = REG_RD && hit(REG_ADDR, CAP_OFS);
    assign rd_ctrl = REG_RD && hit(REG_ADDR, CTRL_OFS);
    assign rd_stat = REG_RD && hit(REG_ADDR, STAT_OFS);

    // ************************************************************
    // EEPROM overridable defaults
    // ************************************************************
    // Time slot count is read-only to software, EEPROM is the only writer
    default_hold #(
        .W(7),
        .RST_VAL(SLOTS_RST)
    ) u_slots (
        .clk(MCLK),
        .rst(SYS_RST),
        .ee_we(EE_LOAD),
        .ee_val(EE_TIME_SLOTS),
        .sw_we(1'b0),
        .sw_val(7'h00),
        .val(slots)
    );

    // Traffic-class map, written by software and by EEPROM
    default_hold #(
        .W(8),
        .RST_VAL(TC_MAP_RST)
    ) u_tc_map (
        .clk(MCLK),
        .rst(SYS_RST),
        .ee_we(EE_LOAD),
        .ee_val(EE_TC_MAP),
        .sw_we(wr_ctrl),
        .sw_val(REG_WDATA[CTRL_MAP_LSB +: 8]),
        .val(tc_map)
    );

    assign TC_MAP = tc_map;
    assign TIME_SLOTS = slots;

    // ************************************************************
    // Control fields
    // ************************************************************
    // Scheme select, illegal codes fold to the default
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            sel_r <= SCHEME_DEFAULT;
        end else if (wr_ctrl) begin
            sel_r <= legal_scheme(REG_WDATA[CTRL_SEL_LSB +: 3]);
        end
    end

    // Channel enable
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            en_r <= VC_EN_RST;
        end else if (wr_ctrl) begin
            en_r <= REG_WDATA[CTRL_EN_BIT];
        end
    end

    // Load strobe is a single pulse and is never stored for read back
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            load_r <= 1'b0;
        end else begin
            load_r <= wr_ctrl && REG_WDATA[CTRL_LOAD_BIT];
        end
    end

    assign ARB_SELECT = sel_r;
    assign VC_ENABLE = en_r;
    assign ARB_LOAD = load_r;

    // ************************************************************
    // Table load sequencer
    // ************************************************************
    // A done seen with no load requested must not clear the flag
    always_comb begin
        load_state_nxt = load_state_r;
        unique case (load_state_r)
            LOAD_IDLE: begin
                if (load_r) begin
                    load_state_nxt = LOAD_BUSY;
                end
            end
            LOAD_BUSY: begin
                if (ARB_LOAD_DONE) begin
                    load_state_nxt = LOAD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            load_state_r <= LOAD_IDLE;
        end else begin
            load_state_r <= load_state_nxt;
        end
    end

    // Dirty flag, a table write in the finishing cycle keeps it set
    table_dirty_flag u_dirty (
        .clk(MCLK),
        .rst(SYS_RST),
        .set_evt(ARB_TABLE_WR),
        .clr_evt((load_state_r == LOAD_BUSY) && ARB_LOAD_DONE),
        .flag(dirty)
    );

    assign TABLE_DIRTY = dirty;

    // Negotiation pending is registered so reads see a clean level
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            neg_r <= 1'b0;
        end else begin
            neg_r <= NEG_PENDING;
        end
    end

    // ************************************************************
    // Read words
    // ************************************************************
    // Constant fields are wired in, reserved bits stay zero
    always_comb begin
        cap_word = 32'h0000_0000;
        cap_word[CAP_ARB_LSB +: 8] = CAP_ARB_RST;
        cap_word[CAP_AS_BIT] = 1'b0;
        cap_word[CAP_SNOOP_BIT] = 1'b0;
        cap_word[CAP_SLOTS_LSB +: 7] = slots;
        cap_word[CAP_TBL_LSB +: 8] = TBL_OFS_RST;
    end

    // Load bit reads zero, VC ID fixed at zero
    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[CTRL_MAP_LSB +: 8] = tc_map;
        ctrl_word[CTRL_LOAD_BIT] = 1'b0;
        ctrl_word[CTRL_SEL_LSB +: 3] = sel_r;
        ctrl_word[CTRL_VCID_LSB +: 3] = VC_ID_RST;
        ctrl_word[CTRL_EN_BIT] = en_r;
    end

    // Status bits
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[STAT_TBL_BIT] = dirty;
        stat_word[STAT_NEG_BIT] = neg_r;
    end

    // Read mux, unmapped addresses answer zero
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (rd_cap) begin
            rd_nxt = cap_word;
        end else if (rd_ctrl) begin
            rd_nxt = ctrl_word;
        end else if (rd_stat) begin
            rd_nxt = stat_word;
        end
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            REG_RDATA <= 32'h0000_0000;
        end else begin
            REG_RDATA <= rd_nxt;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    cap_const_a: assert property (rd_cap |=>
        REG_RDATA[7:0] == CAP_ARB_RST && REG_RDATA[31:24] == TBL_OFS_RST)
        else $error("capability constants wrong");

    as_snoop_a: assert property (rd_cap |=> REG_RDATA[15:8] == 8'h00)
        else $error("capability bits 15:8 not zero");

    snoop_zero_a: assert property (rd_cap |=> !REG_RDATA[CAP_SNOOP_BIT])
        else $error("reject snoop bit not zero");

    slots_read_a: assert property (rd_cap |=>
        REG_RDATA[22:16] == $past(slots) && !REG_RDATA[23])
        else $error("time slot field wrong");

    tbl_ofs_a: assert property (rd_cap |=> REG_RDATA[31:24] == 8'h04)
        else $error("table offset wrong");

    tc_write_a: assert property (wr_ctrl && !EE_LOAD |=>
        TC_MAP == $past(REG_WDATA[7:0]))
        else $error("traffic class map not written");

    load_pulse_a: assert property (wr_ctrl && REG_WDATA[16] |=>
        ARB_LOAD ##1 (!ARB_LOAD || $past(wr_ctrl)))
        else $error("load strobe not one cycle");

    no_load_a: assert property (!(wr_ctrl && REG_WDATA[16]) |=> !ARB_LOAD)
        else $error("spurious load strobe");

    ctrl_read_a: assert property (rd_ctrl |=>
        !REG_RDATA[16] && REG_RDATA[26:24] == 3'h0 && REG_RDATA[31] == $past(en_r))
        else $error("control read back wrong");

    sel_fold_a: assert property (wr_ctrl && REG_WDATA[19:17] != 3'h3 |=>
        ARB_SELECT == 3'h0)
        else $error("illegal scheme kept");

    sel_keep_a: assert property (wr_ctrl && REG_WDATA[19:17] == 3'h3 |=>
        ARB_SELECT == 3'h3 ##1 ARB_SELECT == 3'h3 || $past(wr_ctrl))
        else $error("wrr scheme lost");

    enable_a: assert property (wr_ctrl |=> VC_ENABLE == $past(REG_WDATA[31]))
        else $error("enable not written");

    dirty_set_a: assert property (ARB_TABLE_WR |=> TABLE_DIRTY)
        else $error("dirty flag not set");

    dirty_clr_a: assert property (load_state_r == LOAD_BUSY && ARB_LOAD_DONE
        && !ARB_TABLE_WR |=> !TABLE_DIRTY)
        else $error("dirty flag not cleared by load");

    dirty_hold_a: assert property (load_state_r == LOAD_IDLE && !ARB_TABLE_WR
        |=> TABLE_DIRTY == $past(TABLE_DIRTY))
        else $error("dirty flag moved without cause");

    busy_entry_a: assert property (load_state_r == LOAD_IDLE && ARB_LOAD |=>
        load_state_r == LOAD_BUSY)
        else $error("table load not tracked");

    neg_read_a: assert property (rd_stat |=>
        REG_RDATA[17] == $past(neg_r) && REG_RDATA[16] == $past(dirty))
        else $error("status read wrong");

    neg_clear_a: assert property (!NEG_PENDING ##1 rd_stat |=> !REG_RDATA[17])
        else $error("negotiation bit stuck");

    ee_load_a: assert property (EE_LOAD |=>
        TIME_SLOTS == $past(EE_TIME_SLOTS) && TC_MAP == $past(EE_TC_MAP))
        else $error("eeprom defaults not taken");

    stat_rsvd_a: assert property (rd_stat |=>
        REG_RDATA[15:0] == 16'h0000 && REG_RDATA[31:18] == 14'h0000)
        else $error("status reserved bits not zero");

    ctrl_rsvd_a: assert property (rd_ctrl |=>
        REG_RDATA[15:8] == 8'h00 && REG_RDATA[23:20] == 4'h0 && REG_RDATA[30:27] == 4'h0)
        else $error("control reserved bits not zero");

    idle_rdata_a: assert property (!REG_RD |=> REG_RDATA == 32'h0000_0000)
        else $error("read data outside read slot");

    load_seq_c: cover property (wr_ctrl && REG_WDATA[16] ##1 ARB_LOAD ##[1:20]
        (load_state_r == LOAD_BUSY && ARB_LOAD_DONE));

    set_clr_c: cover property (ARB_TABLE_WR && ARB_LOAD_DONE && load_state_r == LOAD_BUSY);

    fold_c: cover property (wr_ctrl && REG_WDATA[19:17] == 3'h4);

    ee_c: cover property (EE_LOAD ##[1:10] rd_cap);

    ee_sw_c: cover property (EE_LOAD && wr_ctrl);

endmodule

/* tb/tb_vc0_resource_registers.sv */
`timescale 1ns/1ns
// Compare helper: counts every check and reports a mismatch at once
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("ERROR at %0t: got %0h expected %0h", $time, got, exp); end end

module tb_vc0_resource_registers;
    import vc0_res_pkg::*;

    // ************************************************************
    // Stimulus signals and bookkeeping
    // ************************************************************
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic arb_table_wr = 1'b0;
    logic arb_load_done = 1'b0;
    logic neg_pending = 1'b0;
    logic ee_load = 1'b0;
    logic [6:0] ee_time_slots = 7'h00;
    logic [7:0] ee_tc_map = 8'h00;
    logic [31:0] reg_rdata;
    logic [7:0] tc_map;
    logic [6:0] time_slots;
    logic arb_load;
    logic [2:0] arb_select;
    logic vc_enable;
    logic table_dirty;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [7:0] exp_map;
    logic [6:0] exp_slots;
    logic [2:0] exp_sel;
    logic exp_en;
    logic exp_dirty;
    logic exp_neg;

    vc0_resource_registers i_vc0_resource_registers (
        .MCLK(mclk), .SYS_RST(sys_rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .ARB_TABLE_WR(arb_table_wr), .ARB_LOAD_DONE(arb_load_done),
        .NEG_PENDING(neg_pending), .EE_LOAD(ee_load), .EE_TIME_SLOTS(ee_time_slots),
        .EE_TC_MAP(ee_tc_map), .TC_MAP(tc_map), .TIME_SLOTS(time_slots),
        .ARB_LOAD(arb_load), .ARB_SELECT(arb_select), .VC_ENABLE(vc_enable),
        .TABLE_DIRTY(table_dirty)
    );

    // 100 MHz clock
    always #5 mclk = ~mclk;

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            $display("Timeout after %0d cycles", cycles);
            end_sim();
        end
    end

    // ************************************************************
    // Expected register images
    // ************************************************************
    function automatic logic [31:0] cap_word(input logic [6:0] slots);
        return {8'h04, 1'b0, slots, 2'b00, 6'h00, 8'h09};
    endfunction

    function automatic logic [31:0] ctrl_word(input logic [7:0] m, input logic [2:0] s,
                                              input logic e);
        return {e, 4'h0, 3'h0, 4'h0, s, 1'b0, 8'h00, m};
    endfunction

    // Only the two channel-0 schemes survive a write
    function automatic logic [2:0] legal_sel(input logic [2:0] code);
        return (code === 3'h3) ? 3'h3 : 3'h0;
    endfunction

    // ************************************************************
    // Bus tasks: one-cycle strobes, read data in the following cycle
    // ************************************************************
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Reads all three words and compares every output port except ARB_LOAD
    task automatic check_all();
        logic [31:0] d;
        rd(CAP_OFS, d);
        `CHK(d, cap_word(exp_slots))
        rd(CTRL_OFS, d);
        `CHK(d, ctrl_word(exp_map, exp_sel, exp_en))
        rd(STAT_OFS, d);
        `CHK(d, {14'h0, exp_neg, exp_dirty, 16'h0})
        `CHK(tc_map, exp_map)
        `CHK(time_slots, exp_slots)
        `CHK(arb_select, exp_sel)
        `CHK(vc_enable, exp_en)
        `CHK(table_dirty, exp_dirty)
    endtask

    task automatic do_reset();
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        exp_map = 8'hFF;
        exp_slots = 7'h7F;
        exp_sel = 3'h0;
        exp_en = 1'b1;
        exp_dirty = 1'b0;
        exp_neg = 1'b0;
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        logic [31:0] w;
        logic [31:0] d;
        void'($urandom(32'h1c2a));
        do_reset();
        check_all();
        $display("Test reset_values done");
        // Every select code, random map and enable, load bit held low
        for (int i = 0; i < 24; i++) begin
            w = $urandom();
            w[19:17] = i[2:0];
            w[16] = 1'b0;
            wr(CTRL_OFS, w);
            exp_map = w[7:0];
            exp_sel = legal_sel(i[2:0]);
            exp_en = w[31];
            `CHK(arb_load, 1'b0)
            check_all();
        end
        $display("Test control_writes done");
        // Read-only, unmapped and misaligned places ignore writes
        wr(CAP_OFS, 32'hFFFF_FFFF);
        wr(STAT_OFS, 32'hFFFF_FFFF);
        wr(12'h15C, 32'hFFFF_FFFF);
        wr(12'h155, 32'h0000_0000);
        check_all();
        rd(12'h15C, d);
        `CHK(d, 32'h0)
        @(posedge mclk);
        #1;
        `CHK(reg_rdata, 32'h0)
        $display("Test read_only done");
        // EEPROM override of time slots and traffic-class map
        w = $urandom();
        @(posedge mclk);
        ee_load <= 1'b1;
        ee_time_slots <= w[6:0];
        ee_tc_map <= w[15:8];
        @(posedge mclk);
        ee_load <= 1'b0;
        exp_slots = w[6:0];
        exp_map = w[15:8];
        check_all();
        // EEPROM load beside a software write of the map: EEPROM keeps the map
        w = $urandom();
        @(posedge mclk);
        ee_load <= 1'b1;
        ee_tc_map <= w[7:0];
        ee_time_slots <= w[14:8];
        reg_addr <= CTRL_OFS;
        reg_wdata <= {w[31:8], ~w[7:0]} & 32'hFFFE_FFFF;
        reg_wr <= 1'b1;
        @(posedge mclk);
        ee_load <= 1'b0;
        reg_wr <= 1'b0;
        exp_map = w[7:0];
        exp_slots = w[14:8];
        exp_sel = legal_sel(w[19:17]);
        exp_en = w[31];
        check_all();
        $display("Test eeprom_load done");
        // Table dirty: set, ignored done while idle, load, done clears
        @(posedge mclk);
        arb_table_wr <= 1'b1;
        @(posedge mclk);
        arb_table_wr <= 1'b0;
        #1;
        `CHK(table_dirty, 1'b1)
        @(posedge mclk);
        arb_load_done <= 1'b1;
        @(posedge mclk);
        arb_load_done <= 1'b0;
        exp_dirty = 1'b1;
        check_all();
        wr(CTRL_OFS, ctrl_word(exp_map, exp_sel, exp_en) | 32'h0001_0000);
        `CHK(arb_load, 1'b1)
        @(posedge mclk);
        arb_load_done <= 1'b1;
        #1;
        `CHK(arb_load, 1'b0)
        @(posedge mclk);
        arb_load_done <= 1'b0;
        #1;
        `CHK(table_dirty, 1'b0)
        exp_dirty = 1'b0;
        check_all();
        // A table write in the very cycle the load finishes keeps the flag
        wr(CTRL_OFS, ctrl_word(exp_map, exp_sel, exp_en) | 32'h0001_0000);
        @(posedge mclk);
        arb_load_done <= 1'b1;
        arb_table_wr <= 1'b1;
        @(posedge mclk);
        arb_load_done <= 1'b0;
        arb_table_wr <= 1'b0;
        #1;
        `CHK(table_dirty, 1'b1)
        exp_dirty = 1'b1;
        check_all();
        $display("Test table_load done");
        // Negotiation pending follows the arbiter's level
        @(posedge mclk);
        neg_pending <= 1'b1;
        repeat (2) @(posedge mclk);
        exp_neg = 1'b1;
        check_all();
        @(posedge mclk);
        neg_pending <= 1'b0;
        repeat (2) @(posedge mclk);
        exp_neg = 1'b0;
        check_all();
        $display("Test negotiation done");
        // Second reset in mid-run from a non-default state
        wr(CTRL_OFS, 32'h0006_0012);
        @(posedge mclk);
        arb_table_wr <= 1'b1;
        @(posedge mclk);
        arb_table_wr <= 1'b0;
        do_reset();
        check_all();
        $display("Test mid_reset done");
        end_sim();
    end
endmodule
